// [rsdc_pkg.sv]
/*
  constants and types for the switch reset-domain controller.
  assumes a single 20 MHz reference clock drives every register.
*/
package rsdc_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  localparam int unsigned SYS_CLK_MHZ = SYS_CLK_HZ / 1_000_000;
  localparam int unsigned POR_WAIT_NS = 10_000;          // delay after clocks seen
  localparam int unsigned LINK_TRAIN_MS = 80;            // latest start of training
  // least time rounds up
  localparam int unsigned POR_WAIT_CYC_I = (POR_WAIT_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] POR_WAIT_CYC = 8'(POR_WAIT_CYC_I);
  // longest time rounds down
  localparam int unsigned LINK_TRAIN_CYC = LINK_TRAIN_MS * (SYS_CLK_HZ / 1000);
  localparam int unsigned LINK_CNT_W = 21;

  // ****************************************
  // reset domains and synchronisers
  // ****************************************
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned DOM_GLOBAL_RESET_N = 0;
  localparam int unsigned DOM_PERST = 1;
  localparam int unsigned DOM_PORT = 2;
  localparam int unsigned DOM_COUNT = 3;

  // ****************************************
  // eeprom download and header values
  // ****************************************
  localparam logic [3:0] EE_SLAVE_HI = 4'h a;
  localparam int unsigned SB_BUSY_BIT = 4;
  localparam int unsigned SB_ERR_BIT = 0;
  localparam logic [7:0] SB_STATUS_RST = 8'h00;
  localparam logic [7:0] HDR_TYPE_BRIDGE = 8'h01;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // config write field selects
  localparam logic [1:0] FLD_CTRL = 2'h0;
  localparam logic [1:0] FLD_STICKY = 2'h1;
  localparam logic [1:0] FLD_LOADABLE = 2'h2;
  localparam logic [1:0] FLD_GLOBAL = 2'h3;

  typedef enum {POR_WAIT_SUPPLY, POR_WAIT_CLK, POR_DELAY, POR_DONE} rsdc_por_t;
  typedef enum {EE_IDLE, EE_LOAD, EE_END} rsdc_ee_t;
  typedef enum {LT_WAIT, LT_TRAIN} rsdc_lt_t;

endpackage

// [rsdc_rst_if.sv]
/*
  carrier between the controller and one reset-domain synchroniser.
  assumes the controller drives the raw request and reads the domain reset.
*/
`timescale 1ns/1ps
interface rsdc_rst_if;
  logic rawRst;
  logic domRst;
  modport gen (input rawRst, output domRst);
  modport ctl (output rawRst, input domRst);
endinterface // rsdc_rst_if

// [rsdc_rst_sync.sv]
/*
  one reset domain: asserts at once, releases on a clock edge.
  assumes the raw request is a glitch-free combination of pins and flops.
*/
`timescale 1ns/1ps
module rsdc_rst_sync
  import rsdc_pkg::*;
#(
  parameter int unsigned STAGES = SYNC_STAGES
) (
  input wire logic sys_clk,
  rsdc_rst_if.gen rstIf
);

  logic [STAGES-1:0] stage_r;

  // assert with the raw request, release after STAGES clean edges
  always_ff @(posedge sys_clk or posedge rstIf.rawRst) begin
    if (rstIf.rawRst) begin
      stage_r <= '1;
    end else begin
      stage_r <= {stage_r[STAGES-2:0], 1'b0};
    end
  end

  assign rstIf.domRst = stage_r[STAGES-1];

endmodule // rsdc_rst_sync

// [rsdc_switch_reset.sv]
/*
  reset sequencer and reset domains of a multi-port switch: power-on
  delay, global, fundamental and hot reset, strap latch, eeprom download
  start, link training start, and example registers in each domain.
  assumes sys_clk is the reference clock; the eeprom engine, link
  logic and configuration decoder sit outside on the same clock.
*/
// Overview of operation
// - after stable power and clocks, wait 10 us
// - power-on reset clears every register and machine
// - global reset pin low acts like power-on, async
// - latch straps when global reset or perst rises
// - after release, start eeprom download and link setup
// - link training begins within 80 ms
// - perst low clears non-sticky bits, keeps sticky
// - perst low resets non-sticky state machines
// - hot reset moves link into data-link-down
// - data-link-down clears non-sticky non-loadable bits
// - data-link-down spares sticky and eeprom machines
// - port reset is any of the four sources
// - upstream registers default to the port reset
// - sticky by global reset, loadable by perst
// - each downstream port has its own register set
// - every port reports bridge header type 01h; the code has one hdrType, in the upstream set only
// - busy flag bit 4 during download, error bit 0
// - eeprom slave address 1010 plus three pins
`timescale 1ns/1ps
module rsdc_switch_reset
  import rsdc_pkg::*;
#(
  parameter int unsigned STRAP_W = 4,
  parameter int unsigned DN_PORTS = 3,
  parameter int unsigned LINK_TRAIN_MAX_CYC = LINK_TRAIN_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic combined_supply_monitor,
  input wire logic refClockActive,
  input wire logic global_reset_n,
  input wire logic perst_n,
  input wire logic hotResetRx,
  input wire logic [STRAP_W-1:0] strapIn,
  input wire logic eepromPresent,
  input wire logic [2:0] eepromAddrPins,
  input wire logic eepromDone,
  input wire logic eepromErrIn,
  input wire logic eepromWrEn,
  input wire logic [7:0] eepromWrData,
  input wire logic cfgWrEn,
  input wire logic [1:0] cfgPort,
  input wire logic [1:0] cfgField,
  input wire logic [7:0] cfgData,
  output logic porActive,
  output logic globalDomainReset,
  output logic perstDomainReset,
  output logic internal_port_reset,
  output logic dlDown,
  output logic [STRAP_W-1:0] strapLatched,
  output logic eepromStart,
  output logic [6:0] eepromSlaveAddr,
  output logic [7:0] eepromCtlStatus,
  output logic linkTrainEn,
  output logic [7:0] upCtrl,
  output logic [7:0] globalChipCtrl,
  output logic [7:0] stickyBits,
  output logic [7:0] loadableBits,
  output logic [DN_PORTS*8-1:0] dnCtrl,
  output logic [7:0] hdrType
);

  localparam int unsigned PIN_W = STRAP_W + 6;
  localparam logic [LINK_CNT_W-1:0] LINK_LAST = LINK_CNT_W'(LINK_TRAIN_MAX_CYC - 1);
  localparam int POR_D = int'(POR_WAIT_CYC);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [PIN_W-1:0] pinIn;
  logic [PIN_W-1:0] pinS1_r;
  logic [PIN_W-1:0] pinS2_r;
  logic [PIN_W-1:0] pinS3_r;
  logic [PIN_W-1:0] pinOk_r;
  logic supplyOk;
  logic clockOk;
  logic eePresent;
  logic [STRAP_W-1:0] strapSync;
  logic [2:0] addrSync;

  assign pinIn = {eepromAddrPins, strapIn, eepromPresent, refClockActive, combined_supply_monitor};

  // three stages; the first is read only by the second
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinS1_r <= '0;
      pinS2_r <= '0;
      pinS3_r <= '0;
    end else begin
      pinS1_r <= pinIn;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
    end
  end

  // a change counts once stages two and three agree, which hides one-edge slivers
  genvar gp;
  generate
    for (gp = 0; gp < PIN_W; gp++) begin : g_pin
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          pinOk_r[gp] <= 1'b0;
        end else if (pinS2_r[gp] == pinS3_r[gp]) begin
          pinOk_r[gp] <= pinS3_r[gp];
        end
      end
    end
  endgenerate

  assign supplyOk = pinOk_r[0];
  assign clockOk = pinOk_r[1];
  assign eePresent = pinOk_r[2];
  assign strapSync = pinOk_r[STRAP_W+2:3];
  assign addrSync = pinOk_r[PIN_W-1:STRAP_W+3];

  // ****************************************
  // power-on reset sequencer
  // ****************************************
  rsdc_por_t porState_r;
  rsdc_por_t porState_nxt;
  logic [7:0] porCnt_r;
  logic porActive_r;
  logic porCntEnd;

  assign porCntEnd = (porCnt_r == POR_WAIT_CYC - 8'h01);

  // loss of supply or clock restarts the wait, so the delay is always unbroken
  always_comb begin
    porState_nxt = porState_r;
    case (porState_r)
      POR_WAIT_SUPPLY: if (supplyOk) porState_nxt = POR_WAIT_CLK;
      POR_WAIT_CLK: begin
        if (!supplyOk) porState_nxt = POR_WAIT_SUPPLY;
        else if (clockOk) porState_nxt = POR_DELAY;
      end
      POR_DELAY: begin
        if (!supplyOk || !clockOk) porState_nxt = POR_WAIT_SUPPLY;
        else if (porCntEnd) porState_nxt = POR_DONE;
      end
      POR_DONE: if (!supplyOk || !clockOk) porState_nxt = POR_WAIT_SUPPLY;
      default: porState_nxt = POR_WAIT_SUPPLY;
    endcase
  end

  // only sys_rst resets the sequencer itself
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      porState_r <= POR_WAIT_SUPPLY;
      porCnt_r <= 8'h00;
      porActive_r <= 1'b1;
    end else begin
      porState_r <= porState_nxt;
      porCnt_r <= (porState_r == POR_DELAY) ? porCnt_r + 8'h01 : 8'h00;
      porActive_r <= (porState_nxt != POR_DONE);
    end
  end

  // ****************************************
  // reset domains
  // ****************************************
  rsdc_rst_if domIf[DOM_COUNT] ();
  logic grstRst;
  logic perstRst;
  logic portRst;
  logic dlDown_r;

  // nesting: global within perst within port
  assign domIf[DOM_GLOBAL_RESET_N].rawRst = sys_rst | porActive_r | ~global_reset_n;
  assign domIf[DOM_PERST].rawRst = domIf[DOM_GLOBAL_RESET_N].rawRst | ~perst_n;
  assign domIf[DOM_PORT].rawRst = domIf[DOM_PERST].rawRst | dlDown_r;
  assign grstRst = domIf[DOM_GLOBAL_RESET_N].domRst;
  assign perstRst = domIf[DOM_PERST].domRst;
  assign portRst = domIf[DOM_PORT].domRst;

  genvar gd;
  generate
    for (gd = 0; gd < DOM_COUNT; gd++) begin : g_dom
      rsdc_rst_sync #(.STAGES(SYNC_STAGES)) u_sync (
        .sys_clk(sys_clk),
        .rstIf(domIf[gd])
      );
    end
  endgenerate

  // hot reset holds the link in data-link-down while it lasts
  always_ff @(posedge sys_clk or posedge perstRst) begin
    if (perstRst) begin
      dlDown_r <= 1'b0;
    end else begin
      dlDown_r <= hotResetRx;
    end
  end

  // ****************************************
  // release detection and strap latch
  // ****************************************
  logic perstFirst_r;
  logic perstGo;
  logic [STRAP_W-1:0] strap_r;
  logic [6:0] slaveAddr_r;

  // high for one cycle, on the first edge after the perst domain reset releases
  always_ff @(posedge sys_clk or posedge perstRst) begin
    if (perstRst) begin
      perstFirst_r <= 1'b1;
    end else begin
      perstFirst_r <= 1'b0;
    end
  end

  assign perstGo = perstFirst_r & ~perstRst;

  // straps live in the global domain so perst does not lose them
  always_ff @(posedge sys_clk or posedge grstRst) begin
    if (grstRst) begin
      strap_r <= '0;
      slaveAddr_r <= {EE_SLAVE_HI, 3'h0};
    end else if (perstGo) begin
      strap_r <= strapSync;
      slaveAddr_r <= {EE_SLAVE_HI, addrSync};
    end
  end

  // ****************************************
  // eeprom download control
  // ****************************************
  rsdc_ee_t eeState_r;
  logic eeStart_r;
  logic [7:0] sbStatus_r;
  logic eeSettled;

  // perst domain: hot reset must not abort a download
  always_ff @(posedge sys_clk or posedge perstRst) begin
    if (perstRst) begin
      eeState_r <= EE_IDLE;
      eeStart_r <= 1'b0;
      sbStatus_r <= SB_STATUS_RST;
    end else begin
      eeStart_r <= 1'b0;
      case (eeState_r)
        EE_IDLE: begin
          if (perstGo && eePresent) begin
            eeState_r <= EE_LOAD;
            eeStart_r <= 1'b1;
            sbStatus_r[SB_BUSY_BIT] <= 1'b1;
            sbStatus_r[SB_ERR_BIT] <= 1'b0;
          end else if (perstGo) begin
            eeState_r <= EE_END;
          end
        end
        EE_LOAD: begin
          if (eepromDone) begin
            eeState_r <= EE_END;
            sbStatus_r[SB_BUSY_BIT] <= 1'b0;
            sbStatus_r[SB_ERR_BIT] <= eepromErrIn;
          end
        end
        EE_END: eeState_r <= EE_END;
        default: eeState_r <= EE_IDLE;
      endcase
    end
  end

  assign eeSettled = (eeState_r == EE_END);

  // ****************************************
  // link training start
  // ****************************************
  rsdc_lt_t ltState_r;
  logic [LINK_CNT_W-1:0] ltCnt_r;
  logic ltGo;
  logic ltEn_r;

  // waits for the download, but the timer caps the wait
  assign ltGo = eeSettled || (ltCnt_r == LINK_LAST);

  always_ff @(posedge sys_clk or posedge portRst) begin
    if (portRst) begin
      ltState_r <= LT_WAIT;
      ltCnt_r <= '0;
      ltEn_r <= 1'b0;
    end else begin
      ltEn_r <= (ltState_r == LT_TRAIN) || ltGo; // tracks the state so the pin is a flop
      case (ltState_r)
        LT_WAIT: begin
          ltCnt_r <= ltCnt_r + LINK_CNT_W'(1);
          if (ltGo) ltState_r <= LT_TRAIN;
        end
        LT_TRAIN: ltState_r <= LT_TRAIN;
        default: ltState_r <= LT_WAIT;
      endcase
    end
  end

  // ****************************************
  // configuration bits by domain
  // ****************************************
  function automatic logic cfgHit(input logic [1:0] port, input logic [1:0] fld);
    cfgHit = cfgWrEn && (cfgPort == port) && (cfgField == fld);
  endfunction

  logic [7:0] upCtrl_r;
  logic [7:0] global_r;
  logic [7:0] sticky_r;
  logic [7:0] loadable_r;
  logic [7:0] hdr_r;
  logic [7:0] dnCtrl_r [DN_PORTS];

  // upstream default domain is the port reset
  always_ff @(posedge sys_clk or posedge portRst) begin
    if (portRst) begin
      upCtrl_r <= CTRL_RST;
      global_r <= CTRL_RST;
      hdr_r <= HDR_TYPE_BRIDGE;
    end else begin
      if (cfgHit(2'h0, FLD_CTRL)) upCtrl_r <= cfgData;
      if (cfgHit(2'h0, FLD_GLOBAL)) global_r <= cfgData;
      hdr_r <= HDR_TYPE_BRIDGE;
    end
  end

  // sticky bits survive perst and hot reset
  always_ff @(posedge sys_clk or posedge grstRst) begin
    if (grstRst) begin
      sticky_r <= CTRL_RST;
    end else if (cfgHit(2'h0, FLD_STICKY)) begin
      sticky_r <= cfgData;
    end
  end

  // eeprom loadable bits survive hot reset only
  always_ff @(posedge sys_clk or posedge perstRst) begin
    if (perstRst) begin
      loadable_r <= CTRL_RST;
    end else if (eepromWrEn && (eeState_r == EE_LOAD)) begin
      loadable_r <= eepromWrData;
    end else if (cfgHit(2'h0, FLD_LOADABLE)) begin
      loadable_r <= cfgData;
    end
  end

  // one copy of the downstream set per port
  genvar gn;
  generate
    for (gn = 0; gn < DN_PORTS; gn++) begin : g_dn
      always_ff @(posedge sys_clk or posedge portRst) begin
        if (portRst) begin
          dnCtrl_r[gn] <= CTRL_RST;
        end else if (cfgHit(2'(gn + 1), FLD_CTRL)) begin
          dnCtrl_r[gn] <= cfgData;
        end
      end
      assign dnCtrl[gn*8 +: 8] = dnCtrl_r[gn];
    end
  endgenerate

  // ****************************************
  // outputs
  // ****************************************
  assign porActive = porActive_r;
  assign globalDomainReset = grstRst;
  assign perstDomainReset = perstRst;
  assign internal_port_reset = portRst;
  assign dlDown = dlDown_r;
  assign strapLatched = strap_r;
  assign eepromStart = eeStart_r;
  assign eepromSlaveAddr = slaveAddr_r;
  assign eepromCtlStatus = sbStatus_r;
  assign linkTrainEn = ltEn_r;
  assign upCtrl = upCtrl_r;
  assign globalChipCtrl = global_r;
  assign stickyBits = sticky_r;
  assign loadableBits = loadable_r;
  assign hdrType = hdr_r;

  // ****************************************
  // assertions
  // ****************************************
  sequence seqEeLaunch;
    eeStart_r ##0 sbStatus_r[SB_BUSY_BIT];
  endsequence

  sequence seqEeFinish;
    !sbStatus_r[SB_BUSY_BIT] ##0 (eeState_r == EE_END);
  endsequence

  AST_POR_DELAY: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(porActive_r) |-> $past(clockOk, POR_D) && ($past(porState_r, 2) == POR_DELAY))
    else $error("power-on reset released without the full delay");

  AST_GLOBAL_RESET_N_ASYNC: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !global_reset_n |-> grstRst && perstRst && portRst)
    else $error("global reset pin did not reset every domain");

  AST_STRAP_LATCH: assert property (@(posedge sys_clk) disable iff (grstRst)
    perstGo |=> strap_r == $past(strapSync))
    else $error("straps not latched on reset release");

  AST_EE_START: assert property (@(posedge sys_clk) disable iff (perstRst)
    perstGo && eePresent |=> seqEeLaunch)
    else $error("eeprom download not started after release");

  AST_EE_BUSY: assert property (@(posedge sys_clk) disable iff (perstRst)
    (eeState_r == EE_LOAD) && eepromDone |=> seqEeFinish ##0 (sbStatus_r[SB_ERR_BIT] == $past(eepromErrIn)))
    else $error("busy flag or error flag wrong at end of download");

  AST_TRAIN_BOUND: assert property (@(posedge sys_clk) disable iff (portRst)
    (ltState_r == LT_WAIT) |-> ltCnt_r <= LINK_LAST)
    else $error("link training start overran its limit");

  AST_HOT_DOWN: assert property (@(posedge sys_clk) disable iff (perstRst)
    hotResetRx |=> dlDown_r ##1 portRst)
    else $error("hot reset did not reach data-link-down and port reset");

  AST_STICKY_KEEP: assert property (@(posedge sys_clk) disable iff (grstRst)
    $past(perstRst) && perstRst |-> $stable(sticky_r))
    else $error("sticky bits disturbed by perst");

  AST_LOAD_KEEP: assert property (@(posedge sys_clk) disable iff (perstRst)
    dlDown_r && (eeState_r != EE_LOAD) |=> $stable(loadable_r) && $stable(eeState_r))
    else $error("data-link-down disturbed eeprom domain");

  AST_SLAVE_HI: assert property (@(posedge sys_clk) disable iff (grstRst)
    eeStart_r |-> slaveAddr_r[6:3] == EE_SLAVE_HI)
    else $error("eeprom slave address upper nibble wrong");

  AST_HDR_TYPE: assert property (@(posedge sys_clk) disable iff (portRst)
    hdr_r == HDR_TYPE_BRIDGE)
    else $error("header type is not bridge");

endmodule // rsdc_switch_reset

// [rsdc_upstream_model.sv]
/*
  behavioural model of the upstream device: drives the fundamental reset,
  the hot-reset indication, supply-good and reference-clock-detected.
  assumes the caller invokes one task at a time from the bench's main flow.
*/
`timescale 1ns/1ps
module rsdc_upstream_model (
  input wire logic sys_clk,
  output logic perst_n,
  output logic hotResetRx,
  output logic supplyOk,
  output logic refClkOk
);
  // ****************************************
  // power-up state: link held in reset
  // ****************************************
  initial begin
    perst_n = 1'b0;
    hotResetRx = 1'b0;
    supplyOk = 1'b1;
    refClkOk = 1'b1;
  end

  // ****************************************
  // requests, all launched just after an edge
  // ****************************************
  task release_perst();
    @(posedge sys_clk);
    perst_n <= 1'b1;
  endtask

  task assert_perst();
    @(posedge sys_clk);
    perst_n <= 1'b0;
  endtask

  task hot_start();
    @(posedge sys_clk);
    hotResetRx <= 1'b1;
  endtask

  task hot_stop();
    @(posedge sys_clk);
    hotResetRx <= 1'b0;
  endtask

  // reset goes down a full cycle before the clock is lost, never after
  task clock_loss();
    @(posedge sys_clk);
    perst_n <= 1'b0;
    @(posedge sys_clk);
    refClkOk <= 1'b0;
  endtask

  task clock_back();
    @(posedge sys_clk);
    refClkOk <= 1'b1;
  endtask
endmodule // rsdc_upstream_model

// [rsdc_switch_reset_tb_top.sv]
/*
  self-checking bench for the switch reset sequencer: power-on delay,
  downloads, config writes, hot, fundamental and global resets.
  assumes the upstream model file is compiled first; 50 ns clock.
*/
`timescale 1ns/1ps
module rsdc_switch_reset_tb_top;
  import rsdc_pkg::*;
  // short training cap keeps the run brief
  localparam int unsigned LT_CAP = 50;
  localparam int W_GDOM = 0;
  localparam int W_LT = 1;
  localparam int W_START = 2;
  localparam int W_PORT = 3;
  localparam int W_POR = 4;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic globalRstN = 1'b1;
  logic perstN, hotResetRx, supplyOk, refClkOk;
  logic [3:0] strapIn = 4'ha;
  logic eepromPresent = 1'b1;
  logic [2:0] addrPins = 3'h5;
  logic eepromDone = 1'b0;
  logic eepromErrIn = 1'b0;
  logic eepromWrEn = 1'b0;
  logic [7:0] eepromWrData = 8'h00;
  logic cfgWrEn = 1'b0;
  logic [1:0] cfgPort = 2'h0;
  logic [1:0] cfgField = 2'h0;
  logic [7:0] cfgData = 8'h00;
  logic porActive, gDom, pDom, portRst, dlDown, eepromStart, linkTrainEn;
  logic [3:0] strapLatched;
  logic [6:0] slaveAddr;
  logic [7:0] ctlStatus, upCtrl, globalChipCtrl, stickyBits, loadableBits, hdrType;
  logic [23:0] dnCtrl;
  logic [4:0] watch;
  int errTotal = 0;
  int checks = 0;

  assign watch = {porActive, portRst, eepromStart, linkTrainEn, gDom};

  // ****************************************
  // clock, design and upstream model
  // ****************************************
  always #25 sys_clk = ~sys_clk;

  rsdc_switch_reset #(.LINK_TRAIN_MAX_CYC(LT_CAP)) i_rsdc_switch_reset (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .combined_supply_monitor(supplyOk),
    .refClockActive(refClkOk), .global_reset_n(globalRstN), .perst_n(perstN),
    .hotResetRx(hotResetRx), .strapIn(strapIn), .eepromPresent(eepromPresent),
    .eepromAddrPins(addrPins), .eepromDone(eepromDone), .eepromErrIn(eepromErrIn),
    .eepromWrEn(eepromWrEn), .eepromWrData(eepromWrData), .cfgWrEn(cfgWrEn),
    .cfgPort(cfgPort), .cfgField(cfgField), .cfgData(cfgData), .porActive(porActive),
    .globalDomainReset(gDom), .perstDomainReset(pDom), .internal_port_reset(portRst),
    .dlDown(dlDown), .strapLatched(strapLatched), .eepromStart(eepromStart),
    .eepromSlaveAddr(slaveAddr), .eepromCtlStatus(ctlStatus), .linkTrainEn(linkTrainEn),
    .upCtrl(upCtrl), .globalChipCtrl(globalChipCtrl), .stickyBits(stickyBits),
    .loadableBits(loadableBits), .dnCtrl(dnCtrl), .hdrType(hdrType)
  );

  rsdc_upstream_model i_rsdc_upstream_model (
    .sys_clk(sys_clk), .perst_n(perstN), .hotResetRx(hotResetRx),
    .supplyOk(supplyOk), .refClkOk(refClkOk)
  );

  // ****************************************
  // compare, wait and drive helpers
  // ****************************************
  task automatic chk_bit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      errTotal++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // bounded wait; running out ends the run as a failure
  task automatic wait_bit(input int idx, input logic v, input int lim, input string nm);
    int n;
    n = 0;
    while (watch[idx] !== v && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (watch[idx] !== v) begin
      errTotal++;
      $display("ERROR %s expected %b seen %b", nm, v, watch[idx]);
      wrap_up();
    end
  endtask

  task automatic cfg_wr(input logic [1:0] p, input logic [1:0] f, input logic [7:0] d);
    @(posedge sys_clk);
    cfgWrEn <= 1'b1;
    cfgPort <= p;
    cfgField <= f;
    cfgData <= d;
    @(posedge sys_clk);
    cfgWrEn <= 1'b0;
    #1;
  endtask

  task automatic ee_wr(input logic [7:0] d);
    @(posedge sys_clk);
    eepromWrEn <= 1'b1;
    eepromWrData <= d;
    @(posedge sys_clk);
    eepromWrEn <= 1'b0;
    #1;
  endtask

  task automatic ee_done(input logic err);
    @(posedge sys_clk);
    eepromDone <= 1'b1;
    eepromErrIn <= err;
    @(posedge sys_clk);
    eepromDone <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  // power-on reset must cover the whole 10 us delay (200 cycles)
  task automatic por_wait();
    int hi;
    hi = 0;
    repeat (200) begin
      @(posedge sys_clk);
      #1;
      if (porActive === 1'b1) hi++;
    end
    chk_bit("porHeld", 1'b1, logic'(hi == 200));
    wait_bit(W_POR, 1'b0, 40, "porActive");
    chk_bit("portRstPerstLow", 1'b1, portRst);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic sc_power_on();
    chk_byte("hdrType", 8'h01, hdrType);
    chk_byte("slaveRst", 8'h50, {1'b0, slaveAddr});
    chk_bit("portRstPor", 1'b1, portRst);
    por_wait();
  endtask

  task automatic sc_first_download();
    i_rsdc_upstream_model.release_perst();
    wait_bit(W_START, 1'b1, 10, "eepromStart");
    chk_byte("statusBusy", 8'h10, ctlStatus);
    chk_byte("straps", 8'h0a, {4'h0, strapLatched});
    chk_byte("slaveAddr", 8'h55, {1'b0, slaveAddr});
    strapIn <= 4'h3;
    ee_wr(8'h3c);
    ee_done(1'b1);
    chk_byte("statusErr", 8'h01, ctlStatus);
    wait_bit(W_LT, 1'b1, 3, "linkTrainEn");
    ee_wr(8'hff);
    chk_byte("loadableIdle", 8'h3c, loadableBits);
    chk_byte("strapsHeld", 8'h0a, {4'h0, strapLatched});
  endtask

  task automatic sc_cfg();
    wait_bit(W_PORT, 1'b0, 8, "portRst");
    cfg_wr(2'h0, FLD_CTRL, 8'h81);
    cfg_wr(2'h0, FLD_STICKY, 8'h42);
    cfg_wr(2'h0, FLD_LOADABLE, 8'h24);
    cfg_wr(2'h0, FLD_GLOBAL, 8'h18);
    for (int p = 1; p <= 3; p++) cfg_wr(2'(p), FLD_CTRL, 8'(8'h11 * p));
    cfg_wr(2'h1, FLD_STICKY, 8'hee);
    chk_byte("upCtrl", 8'h81, upCtrl);
    chk_byte("sticky", 8'h42, stickyBits);
    chk_byte("loadable", 8'h24, loadableBits);
    chk_byte("globalCtrl", 8'h18, globalChipCtrl);
    for (int p = 1; p <= 3; p++) chk_byte("dnCtrl", 8'(8'h11 * p), dnCtrl[8*(p-1) +: 8]);
  endtask

  task automatic sc_hot();
    i_rsdc_upstream_model.hot_start();
    repeat (3) @(posedge sys_clk);
    #1;
    chk_bit("dlDown", 1'b1, dlDown);
    chk_bit("portRstHot", 1'b1, portRst);
    chk_bit("perstDomHot", 1'b0, pDom);
    chk_bit("trainHot", 1'b0, linkTrainEn);
    chk_byte("upCtrlHot", 8'h00, upCtrl);
    chk_byte("dnCtrlHot", 8'h00, dnCtrl[15:8]);
    chk_byte("stickyHot", 8'h42, stickyBits);
    chk_byte("loadableHot", 8'h24, loadableBits);
    i_rsdc_upstream_model.hot_stop();
    wait_bit(W_PORT, 1'b0, 8, "portRstHotEnd");
    wait_bit(W_LT, 1'b1, LT_CAP + 5, "trainAfterHot");
  endtask

  task automatic sc_perst();
    i_rsdc_upstream_model.assert_perst();
    eepromPresent <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk_byte("loadablePerst", 8'h00, loadableBits);
    chk_byte("stickyPerst", 8'h42, stickyBits);
    chk_byte("upCtrlPerst", 8'h00, upCtrl);
    chk_bit("trainPerst", 1'b0, linkTrainEn);
    i_rsdc_upstream_model.release_perst();
    wait_bit(W_PORT, 1'b0, 10, "portRstPerstEnd");
    @(posedge sys_clk);
    #1;
    chk_byte("strapsNew", 8'h03, {4'h0, strapLatched});
    chk_byte("statusNoRom", 8'h00, ctlStatus);
    wait_bit(W_LT, 1'b1, LT_CAP + 5, "trainNoRom");
  endtask

  task automatic sc_global();
    @(posedge sys_clk);
    eepromPresent <= 1'b1;
    globalRstN <= 1'b0;
    #1;
    chk_bit("globalDomAsync", 1'b1, gDom);
    chk_bit("portRstGlobal", 1'b1, portRst);
    repeat (4) @(posedge sys_clk);
    #1;
    chk_byte("stickyGlobal", 8'h00, stickyBits);
    chk_byte("globalCtrlRst", 8'h00, globalChipCtrl);
    @(posedge sys_clk);
    globalRstN <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk_bit("globalDomSync", 1'b1, gDom);
    wait_bit(W_GDOM, 1'b0, 6, "globalDomEnd");
    wait_bit(W_START, 1'b1, 10, "startGlobal");
    wait_bit(W_LT, 1'b1, LT_CAP + 5, "trainCap");
    ee_done(1'b0);
    chk_byte("statusOk", 8'h00, ctlStatus);
  endtask

  task automatic sc_clock_loss();
    i_rsdc_upstream_model.clock_loss();
    wait_bit(W_POR, 1'b1, 12, "porRestart");
    i_rsdc_upstream_model.clock_back();
    por_wait();
    i_rsdc_upstream_model.release_perst();
    wait_bit(W_PORT, 1'b0, 10, "portRstFinal");
  endtask

  // ****************************************
  // verdict and main sequence
  // ****************************************
  task automatic wrap_up();
    $display("mismatches %0d, comparisons %0d", errTotal, checks);
    if (errTotal == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    sc_power_on();
    sc_first_download();
    sc_cfg();
    sc_hot();
    sc_perst();
    sc_global();
    sc_clock_loss();
    wrap_up();
  end
endmodule // rsdc_switch_reset_tb_top
